// >>> core/fifo_port_defs.svh
// Constants for the module FIFO port access block: offsets, fields, resets.
// Assumes a single hclk domain and a 32-bit AHB-Lite register slave.
// Notes on behaviour
// - Six input, six output channels, shared buses.
// - Read and write sides run independently; in loopback the read side waits on the write side.
// - Drive one continuous clock per side.
// - Per-channel enable selects accessed FIFO.
// - At most one input enable/output enable.
// - One input word per FIFO clock possible.
// - Near empty: single read, then check empty.
// - One output write unless multi-write chosen.
// - One output word per FIFO clock possible.
// - Near full: single write, then check full.
// - Buffered clocks return on dedicated inputs.
`ifndef FIFO_PORT_DEFS_SVH
`define FIFO_PORT_DEFS_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_WMASK 8'h04
`define OFS_FLAGS 8'h08
`define OFS_RXDATA 8'h0C
`define OFS_TXDATA 8'h10
`define OFS_ISTAT 8'h14
`define OFS_ICLR 8'h18
`define OFS_IEN 8'h1C

// Control register fields
`define CTRL_RD_GO 0
`define CTRL_WR_GO 1
`define CTRL_LOOP 2
`define CTRL_MULTI 3
`define CTRL_RSEL_LO 4
`define CTRL_WSEL_LO 8
`define CTRL_RST 32'h0000_0000

// Flag register fields
`define FLG_EMPTY_LO 0
`define FLG_AEMPTY_LO 6
`define FLG_FULL_LO 12
`define FLG_AFULL_LO 18
`define FLG_RXV 24
`define FLG_TXP 25
`define FLG_IN_PH 26
`define FLG_OUT_PH 27

// Interrupt event bits
`define EV_RX 0
`define EV_TX 1
`define EV_RX_STALL 2
`define EV_TX_STALL 3
`define EV_RST 4'h0

// FIFO clock half period in hclk cycles
`define FIFO_CLK_HALF 2

`endif

// >>> core/fifo_port_pkg.sv
// Types shared by the FIFO port access block.
// Assumes the constants header is included where offsets are needed.
package fifo_port_pkg;
   // Shared data bus word
   typedef logic [31:0] word_t;
   // Register selected by the bus decode
   typedef enum {REG_CTRL, REG_WMASK, REG_FLAGS, REG_RXDATA, REG_TXDATA,
                 REG_ISTAT, REG_ICLR, REG_IEN, REG_NONE} reg_sel_t;
endpackage : fifo_port_pkg

// >>> core/flag_sample.sv
// Registers a group of FIFO status flags on a strobe.
// Assumes flags are synchronous to hclk and the strobe is one cycle wide.
`timescale 1ns/10ps
`default_nettype none
module flag_sample #(
   parameter int N = 6
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Sample point and flags
   input wire logic strobe,
   input wire logic [N-1:0] flags,
   input wire logic [N-1:0] rst_val,
   output logic [N-1:0] flags_r
);
   // Hold the flags seen at the last FIFO clock sample point
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flags_r <= '1;
      else if (strobe)
         flags_r <= flags;
   end
   // Reset value port kept for width matching of inverted flags
   logic unused_rst;
   assign unused_rst = ^rst_val;
endmodule : flag_sample
`default_nettype wire

// >>> core/module_fifo_port_access.sv
// Carrier FIFO port access: drives both FIFO clocks, enables and data.
// Assumes carrier FIFOs and flags are synchronous to hclk; AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
`include "fifo_port_defs.svh"
module module_fifo_port_access #(
   parameter int NUM_IN = 6,
   parameter int NUM_OUT = 6,
   parameter int HALF = `FIFO_CLK_HALF
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Input FIFO side
   output logic in_fifo_clk,
   input wire logic in_clk_fb,
   output logic [NUM_IN-1:0] in_rd_en,
   output logic [NUM_IN-1:0] in_out_en,
   input wire logic [31:0] in_data,
   input wire logic [NUM_IN-1:0] in_empty,
   input wire logic [NUM_IN-1:0] in_aempty,
   // Output FIFO side
   output logic out_fifo_clk,
   input wire logic out_clk_fb,
   output logic [NUM_OUT-1:0] out_wr_en,
   output logic [31:0] out_data,
   input wire logic [NUM_OUT-1:0] out_full,
   input wire logic [NUM_OUT-1:0] out_afull,
   // Interrupt
   output logic irq
);
   // Clock divider state
   logic [7:0] div_r;
   logic clk_r;
   logic term;
   logic rise_p;
   logic fall_p;
   // Software registers
   logic [31:0] ctrl_r;
   logic [NUM_OUT-1:0] wmask_r;
   logic [3:0] istat_r;
   logic [3:0] ien_r;
   // Data holding
   fifo_port_pkg::word_t rx_r;
   logic rxv_r;
   fifo_port_pkg::word_t tx_r;
   logic txp_r;
   // Access in flight
   logic rd_act_r;
   logic wr_act_r;
   // Registered flags
   logic [NUM_IN-1:0] empty_r;
   logic [NUM_IN-1:0] aempty_r;
   logic [NUM_OUT-1:0] full_r;
   logic [NUM_OUT-1:0] afull_r;
   // Feedback phase check
   logic in_fb_r;
   logic out_fb_r;
   logic clk_d_r;
   logic in_ph_r;
   logic out_ph_r;
   // Bus data phase
   logic wr_ph_r;
   fifo_port_pkg::reg_sel_t wsel_r;

   // Divider: FIFO clocks are hclk / (2*HALF), free running
   assign term = (div_r == 8'(HALF - 1));
   assign rise_p = term & ~clk_r;
   assign fall_p = term & clk_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         div_r <= 8'h00;
      else
         div_r <= term ? 8'h00 : div_r + 8'h01;
   end

   // Same rate on both sides; never gated
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clk_r <= 1'b0;
         in_fifo_clk <= 1'b0;
         out_fifo_clk <= 1'b0;
      end
      else
      begin
         clk_r <= clk_r ^ term;
         in_fifo_clk <= clk_r ^ term;
         out_fifo_clk <= clk_r ^ term;
      end
   end

   // Flags sampled at the low-going point, after the FIFO edge
   flag_sample #(.N(NUM_IN)) u_in_empty (
      .hclk(hclk), .hresetn(hresetn), .strobe(fall_p),
      .flags(in_empty), .rst_val('1), .flags_r(empty_r));
   flag_sample #(.N(NUM_IN)) u_in_aempty (
      .hclk(hclk), .hresetn(hresetn), .strobe(fall_p),
      .flags(in_aempty), .rst_val('1), .flags_r(aempty_r));
   flag_sample #(.N(NUM_OUT)) u_out_full (
      .hclk(hclk), .hresetn(hresetn), .strobe(fall_p),
      .flags(out_full), .rst_val('1), .flags_r(full_r));
   flag_sample #(.N(NUM_OUT)) u_out_afull (
      .hclk(hclk), .hresetn(hresetn), .strobe(fall_p),
      .flags(out_afull), .rst_val('1), .flags_r(afull_r));

   // Control fields
   logic rd_go;
   logic wr_go;
   logic loop;
   logic multi;
   logic [2:0] rsel;
   logic [2:0] wsel;
   assign rd_go = ctrl_r[`CTRL_RD_GO];
   assign wr_go = ctrl_r[`CTRL_WR_GO];
   assign loop = ctrl_r[`CTRL_LOOP];
   assign multi = ctrl_r[`CTRL_MULTI];
   assign rsel = ctrl_r[`CTRL_RSEL_LO +: 3];
   assign wsel = ctrl_r[`CTRL_WSEL_LO +: 3];

   // Read side decision; in loopback it also depends on the write side's wr_hot, afull_r and txp_r
   logic rsel_ok;
   logic [NUM_IN-1:0] rd_hot;
   logic rd_flag_ok;
   logic rd_room;
   logic rd_launch;
   logic cap;
   logic [NUM_OUT-1:0] wr_hot; // Output FIFOs targeted, also gates loopback reads
   assign rsel_ok = (32'(rsel) < NUM_IN);
   assign rd_hot = rsel_ok ? NUM_IN'(1) << rsel : '0;
   assign rd_flag_ok = ~|(rd_hot & empty_r) &
                       ~(|(rd_hot & aempty_r) & rd_act_r);
   assign cap = fall_p & rd_act_r;
   // Loopback streams while output has room; else one word at a time
   assign rd_room = loop ? (~|(wr_hot & afull_r) | (~txp_r & ~rd_act_r))
                         : (~rxv_r & ~rd_act_r);
   assign rd_launch = fall_p & rd_go & rsel_ok & rd_flag_ok & rd_room;

   // Write side decision
   logic wsel_ok;
   logic wr_flag_ok;
   logic wr_launch;
   assign wsel_ok = (32'(wsel) < NUM_OUT);
   assign wr_hot = multi ? wmask_r
                 : (wsel_ok ? NUM_OUT'(1) << wsel : '0);
   assign wr_flag_ok = ~|(wr_hot & full_r) &
                       ~(|(wr_hot & afull_r) & wr_act_r);
   assign wr_launch = fall_p & wr_go & txp_r & (|wr_hot) & wr_flag_ok;

   // Enables change away from the FIFO rising edge, one period each
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_rd_en <= '0;
         in_out_en <= '0;
         out_wr_en <= '0;
         out_data <= 32'h0000_0000;
         rd_act_r <= 1'b0;
         wr_act_r <= 1'b0;
      end
      else if (fall_p)
      begin
         in_rd_en <= rd_launch ? rd_hot : '0;
         in_out_en <= rd_launch ? rd_hot : '0;
         out_wr_en <= wr_launch ? wr_hot : '0;
         if (wr_launch)
            out_data <= tx_r;
         rd_act_r <= rd_launch;
         wr_act_r <= wr_launch;
      end
   end

   // Bus decode
   logic acc;
   fifo_port_pkg::reg_sel_t asel;
   logic rd_acc;
   logic pop;
   logic sw_tx;
   logic [3:0] iclr;
   logic [3:0] ev;
   assign acc = hsel & hready & htrans[1];
   assign asel = (haddr == `OFS_CTRL) ? fifo_port_pkg::REG_CTRL :
                 (haddr == `OFS_WMASK) ? fifo_port_pkg::REG_WMASK :
                 (haddr == `OFS_FLAGS) ? fifo_port_pkg::REG_FLAGS :
                 (haddr == `OFS_RXDATA) ? fifo_port_pkg::REG_RXDATA :
                 (haddr == `OFS_TXDATA) ? fifo_port_pkg::REG_TXDATA :
                 (haddr == `OFS_ISTAT) ? fifo_port_pkg::REG_ISTAT :
                 (haddr == `OFS_ICLR) ? fifo_port_pkg::REG_ICLR :
                 (haddr == `OFS_IEN) ? fifo_port_pkg::REG_IEN :
                 fifo_port_pkg::REG_NONE;
   assign rd_acc = acc & ~hwrite;
   assign pop = rd_acc & (asel == fifo_port_pkg::REG_RXDATA) & rxv_r;
   assign sw_tx = wr_ph_r & (wsel_r == fifo_port_pkg::REG_TXDATA) & ~loop;
   assign iclr = (wr_ph_r & (wsel_r == fifo_port_pkg::REG_ICLR)) ? hwdata[3:0] : 4'h0;

   // Status view
   logic [31:0] flags_v;
   assign flags_v = {4'h0, out_ph_r, in_ph_r, txp_r, rxv_r,
                     6'(afull_r), 6'(full_r), 6'(aempty_r), 6'(empty_r)};

   // Read data mux; unmapped and write-only read zero
   logic [31:0] rdata_nxt;
   assign rdata_nxt = (asel == fifo_port_pkg::REG_CTRL) ? ctrl_r :
                      (asel == fifo_port_pkg::REG_WMASK) ? 32'(wmask_r) :
                      (asel == fifo_port_pkg::REG_FLAGS) ? flags_v :
                      (asel == fifo_port_pkg::REG_RXDATA) ? rx_r :
                      (asel == fifo_port_pkg::REG_ISTAT) ? 32'(istat_r) :
                      (asel == fifo_port_pkg::REG_IEN) ? 32'(ien_r) :
                      32'h0000_0000;

   // Address phase capture; zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ph_r <= 1'b0;
         wsel_r <= fifo_port_pkg::REG_NONE;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_ph_r <= acc & hwrite;
         wsel_r <= asel;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rd_acc)
            hrdata <= rdata_nxt;
      end
   end

   // Software writable registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_r <= `CTRL_RST;
         wmask_r <= '0;
         ien_r <= `EV_RST;
      end
      else if (wr_ph_r)
      begin
         if (wsel_r == fifo_port_pkg::REG_CTRL)
            ctrl_r <= hwdata & 32'h0000_077F;
         if (wsel_r == fifo_port_pkg::REG_WMASK)
            wmask_r <= hwdata[NUM_OUT-1:0];
         if (wsel_r == fifo_port_pkg::REG_IEN)
            ien_r <= hwdata[3:0];
      end
   end

   // Received word holding; a capture beats a pop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_r <= 32'h0000_0000;
         rxv_r <= 1'b0;
      end
      else if (cap & ~loop)
      begin
         rx_r <= in_data;
         rxv_r <= 1'b1;
      end
      else if (pop)
         rxv_r <= 1'b0;
   end

   // Transmit word: from software or looped from input
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_r <= 32'h0000_0000;
         txp_r <= 1'b0;
      end
      else if (cap & loop)
      begin
         tx_r <= in_data;
         txp_r <= 1'b1;
      end
      else if (sw_tx & ~txp_r)
      begin
         tx_r <= hwdata;
         txp_r <= 1'b1;
      end
      else if (wr_launch)
         txp_r <= 1'b0;
   end

   // Events: capture, write, stalls on flags
   assign ev[`EV_RX] = cap;
   assign ev[`EV_TX] = wr_launch;
   assign ev[`EV_RX_STALL] = fall_p & rd_go & rsel_ok & ~rd_flag_ok;
   assign ev[`EV_TX_STALL] = fall_p & wr_go & txp_r & ~wr_flag_ok;

   // Sticky status, set wins over clear; level interrupt
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         istat_r <= `EV_RST;
         irq <= 1'b0;
      end
      else
      begin
         istat_r <= (istat_r & ~iclr) | ev;
         irq <= |(((istat_r & ~iclr) | ev) & ien_r);
      end
   end

   // Returned buffered clocks compared to the driven clock one cycle on
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_fb_r <= 1'b0;
         out_fb_r <= 1'b0;
         clk_d_r <= 1'b0;
         in_ph_r <= 1'b0;
         out_ph_r <= 1'b0;
      end
      else
      begin
         in_fb_r <= in_clk_fb;
         out_fb_r <= out_clk_fb;
         clk_d_r <= in_fifo_clk;
         in_ph_r <= (in_fb_r == clk_d_r);
         out_ph_r <= (out_fb_r == clk_d_r);
      end
   end

   // Transfer size is always a word; unused bits noted
   logic unused_bus;
   assign unused_bus = ^{hsize, htrans[0], rdata_nxt[31:28]};
endmodule : module_fifo_port_access
`default_nettype wire

// >>> verif/fifo_carrier_model.sv
// Behavioural carrier FIFOs: six input and six output channels.
// Assumes enables are sampled at each FIFO clock rise.
`timescale 1ns/10ps
`default_nettype none
module fifo_carrier_model #(
   parameter int DEPTH = 6,
   parameter int ROOM = 8
) (
   // Input side
   input wire logic in_fifo_clk,
   input wire logic [5:0] in_rd_en,
   input wire logic [5:0] in_out_en,
   output logic [31:0] in_data,
   output logic [5:0] in_empty,
   output logic [5:0] in_aempty,
   // Output side
   input wire logic out_fifo_clk,
   input wire logic [5:0] out_wr_en,
   input wire logic [31:0] out_data,
   output logic [5:0] out_full,
   output logic [5:0] out_afull
);
   int lvl [6] = '{6{DEPTH}}; // Words left per input FIFO
   int got [6] = '{6{0}}; // Words taken per output FIFO
   int bad = 0; // Reads when empty, writes when full
   logic [31:0] last [6]; // Last word taken per output FIFO
   logic [31:0] q = 32'h0000_0000; // Word on the read port
   // Bus carries the word only while enabled, else junk
   assign in_data = (in_out_en != 6'h00) ? q : ~q;
   // Flags from fill levels
   always_comb
   begin
      for (int i = 0; i < 6; i++)
      begin
         in_empty[i] = (lvl[i] == 0);
         in_aempty[i] = (lvl[i] <= 4);
         out_full[i] = (got[i] >= ROOM);
         out_afull[i] = (ROOM - got[i] <= 4);
      end
   end
   // Pop on the input clock rise
   always @(posedge in_fifo_clk)
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (in_rd_en[i] && lvl[i] == 0)
            bad++;
         else if (in_rd_en[i])
         begin
            q <= {16'hA000, 8'(i), 8'(DEPTH - lvl[i])};
            lvl[i]--;
         end
      end
   end
   // Push on the output clock rise
   always @(posedge out_fifo_clk)
   begin
      for (int i = 0; i < 6; i++)
      begin
         if (out_wr_en[i] && got[i] >= ROOM)
            bad++;
         else if (out_wr_en[i])
         begin
            got[i]++;
            last[i] = out_data;
         end
      end
   end
endmodule : fifo_carrier_model
`default_nettype wire

// >>> verif/module_fifo_port_access_assertions.sv
// Checker for the carrier-side pins of the FIFO port access block.
// Assumes one hclk domain; bound from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module fifo_port_checker #(
   parameter int NUM_IN = 6,
   parameter int NUM_OUT = 6,
   parameter int HALF = 2
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Input FIFO side
   input wire logic in_fifo_clk,
   input wire logic [NUM_IN-1:0] in_rd_en,
   input wire logic [NUM_IN-1:0] in_out_en,
   input wire logic [NUM_IN-1:0] in_empty,
   input wire logic [NUM_IN-1:0] in_aempty,
   // Output FIFO side
   input wire logic out_fifo_clk,
   input wire logic [NUM_OUT-1:0] out_wr_en,
   input wire logic [NUM_OUT-1:0] out_full
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic ip_r; // Input clock one sample back
   logic op_r; // Output clock one sample back
   logic [7:0] ic_r; // Samples the input clock has held
   logic [7:0] oc_r; // Samples the output clock has held
   // Hold counters for both FIFO clocks
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ip_r <= 1'b0;
         op_r <= 1'b0;
         ic_r <= 8'h00;
         oc_r <= 8'h00;
      end
      else
      begin
         ip_r <= in_fifo_clk;
         op_r <= out_fifo_clk;
         ic_r <= (in_fifo_clk != ip_r) ? 8'h00 : ic_r + 8'h01;
         oc_r <= (out_fifo_clk != op_r) ? 8'h00 : oc_r + 8'h01;
      end
   end
   // Launch points of each side
   sequence s_in_fall;
      $fell(in_fifo_clk);
   endsequence
   sequence s_out_fall;
      $fell(out_fifo_clk);
   endsequence
   property p_in_oe_one;
      $onehot0(in_out_en);
   endproperty
   a_in_oe_one: assert property (p_in_oe_one) else $error("several input output enables");
   property p_in_rd_pair;
      in_rd_en == '0 || in_rd_en == in_out_en;
   endproperty
   a_in_rd_pair: assert property (p_in_rd_pair) else $error("read enable without its output enable");
   property p_in_clk;
      (ic_r <= HALF) && (in_fifo_clk == ip_r || ic_r >= HALF - 1);
   endproperty
   a_in_clk: assert property (p_in_clk) else $error("input FIFO clock not steady");
   property p_out_clk;
      (oc_r <= HALF) && (out_fifo_clk == op_r || oc_r >= HALF - 1);
   endproperty
   a_out_clk: assert property (p_out_clk) else $error("output FIFO clock not steady");
   property p_in_edge;
      $changed(in_rd_en) |-> s_in_fall;
   endproperty
   a_in_edge: assert property (p_in_edge) else $error("read enable moved off the launch point");
   property p_out_edge;
      $changed(out_wr_en) |-> s_out_fall;
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("write enable moved off the launch point");
   property p_in_empty;
      s_in_fall |-> (in_rd_en & $past(in_empty, 2*HALF+1)) == '0;
   endproperty
   a_in_empty: assert property (p_in_empty) else $error("read launched on empty FIFO");
   property p_in_aempty;
      s_in_fall |-> (in_rd_en & $past(in_rd_en, 2*HALF) & $past(in_aempty, 2*HALF+1)) == '0;
   endproperty
   a_in_aempty: assert property (p_in_aempty) else $error("back to back read when near empty");
   property p_out_full;
      s_out_fall |-> (out_wr_en & $past(out_full, 2*HALF+1)) == '0;
   endproperty
   a_out_full: assert property (p_out_full) else $error("write launched on full FIFO");
endmodule : fifo_port_checker
`default_nettype wire

// >>> verif/module_fifo_port_access_tb.sv
// Self-checking bench for the FIFO port access block.
// Assumes the carrier model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module module_fifo_port_access_tb;
   logic hclk = 1'b0; // Bus clock
   logic hresetn = 1'b0; // Active low reset
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010; // Whole words only
   logic [31:0] hwdata = 32'h0000_0000;
   wire logic hreadyout, hresp, irq, in_fifo_clk, out_fifo_clk;
   wire logic [31:0] hrdata, in_data, out_data;
   wire logic [5:0] in_rd_en, in_out_en, in_empty, in_aempty, out_wr_en, out_full, out_afull;
   int miscompares = 0;
   int comparisons = 0;
   logic [31:0] rd; // Last bus read
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
   // Address, written word, expected read back
   row_t rows [4] = '{'{8'h00, 32'h0000_0550, 32'h0000_0550}, '{8'h04, 32'h0000_003F, 32'h0000_003F},
                      '{8'h1C, 32'h0000_0005, 32'h0000_0005}, '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000}};
   // Free running bus clock
   initial
   begin
      forever #2 hclk = ~hclk;
   end
   module_fifo_port_access #(.HALF(2)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_fifo_clk(in_fifo_clk),
      .in_clk_fb(in_fifo_clk), .in_rd_en(in_rd_en), .in_out_en(in_out_en), .in_data(in_data),
      .in_empty(in_empty), .in_aempty(in_aempty), .out_fifo_clk(out_fifo_clk), .out_clk_fb(out_fifo_clk),
      .out_wr_en(out_wr_en), .out_data(out_data), .out_full(out_full), .out_afull(out_afull), .irq(irq));
   fifo_carrier_model u_far (.in_fifo_clk(in_fifo_clk), .in_rd_en(in_rd_en), .in_out_en(in_out_en),
      .in_data(in_data), .in_empty(in_empty), .in_aempty(in_aempty), .out_fifo_clk(out_fifo_clk),
      .out_wr_en(out_wr_en), .out_data(out_data), .out_full(out_full), .out_afull(out_afull));
   // Compare and count
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // One single transfer, entered just after a rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
      chk("hresp", 32'(hresp), 32'h0000_0000);
   endtask : bus
   // Verdict and end of run
   task automatic wrap_up;
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge hclk);
      miscompares++;
      wrap_up();
   end
   // Main sequence
   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("enables", {26'h000_0000, in_rd_en}, 32'h0000_0000);
      bus(8'h00, 1'b0, 32'h0000_0000);
      chk("ctrl reset", rd, 32'h0000_0000);
      foreach (rows[i])
      begin
         bus(rows[i].a, 1'b1, rows[i].w);
         bus(rows[i].a, 1'b0, 32'h0000_0000);
         chk("register", rd, rows[i].e);
      end
      // Stream FIFO 2 into FIFO 3 until the source runs dry
      bus(8'h00, 1'b1, 32'h0000_0327);
      for (int k = 0; k < 800 && u_far.got[3] < 6; k++)
         @(posedge hclk);
      chk("loop count", 32'(u_far.got[3]), 32'h0000_0006);
      chk("loop last", u_far.last[3], 32'hA000_0205);
      chk("spill", 32'(u_far.got.sum()), 32'h0000_0006);
      chk("overrun", 32'(u_far.bad), 32'h0000_0000);
      bus(8'h08, 1'b0, 32'h0000_0000);
      chk("flags", rd & 32'h0020_0004, 32'h0020_0004);
      chk("phase", rd & 32'h0C00_0000, 32'h0C00_0000);
      bus(8'h00, 1'b1, 32'h0000_0000);
      // Single software read from FIFO 0
      bus(8'h18, 1'b1, 32'h0000_000F);
      bus(8'h00, 1'b1, 32'h0000_0001);
      rd = 32'h0000_0000;
      for (int k = 0; k < 200 && rd[0] !== 1'b1; k++)
         bus(8'h14, 1'b0, 32'h0000_0000);
      bus(8'h00, 1'b1, 32'h0000_0000);
      bus(8'h0C, 1'b0, 32'h0000_0000);
      chk("rx word", rd, 32'hA000_0000);
      // Single software write to FIFO 1
      bus(8'h00, 1'b1, 32'h0000_0102);
      bus(8'h10, 1'b1, 32'h1234_5678);
      for (int k = 0; k < 200 && u_far.got[1] < 1; k++)
         @(posedge hclk);
      chk("tx word", u_far.last[1], 32'h1234_5678);
      // Multi-write: one word into every FIFO of the mask
      bus(8'h00, 1'b1, 32'h0000_010A);
      bus(8'h10, 1'b1, 32'h5A5A_0001);
      for (int k = 0; k < 200 && u_far.got[5] < 1; k++)
         @(posedge hclk);
      chk("multi count", 32'(u_far.got.sum()), 32'h0000_000D);
      chk("multi last", u_far.last[5], 32'h5A5A_0001);
      // Interrupt masked, raised, cleared
      bus(8'h1C, 1'b1, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      chk("irq masked", 32'(irq), 32'h0000_0000);
      bus(8'h1C, 1'b1, 32'h0000_0002);
      repeat (2) @(posedge hclk);
      chk("irq up", 32'(irq), 32'h0000_0001);
      bus(8'h18, 1'b1, 32'h0000_0002);
      repeat (2) @(posedge hclk);
      chk("irq clear", 32'(irq), 32'h0000_0000);
      wrap_up();
   end
endmodule : module_fifo_port_access_tb
bind module_fifo_port_access fifo_port_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .HALF(HALF)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .in_fifo_clk(in_fifo_clk), .in_rd_en(in_rd_en), .in_out_en(in_out_en),
   .in_empty(in_empty), .in_aempty(in_aempty), .out_fifo_clk(out_fifo_clk), .out_wr_en(out_wr_en),
   .out_full(out_full));
`default_nettype wire
